// ==== rtl/scdd_cfg_if.sv ====
// Configuration carrier from the register file to the divider and delay.
// Assumes the top drives all config and the divider drives the tick.
`default_nettype none
interface scdd_cfg_if;
	logic [1:0] ratio;           // Divide ratio code
	logic [1:0] syncState;       // Count loaded on sysref
	logic sysrefEn;              // Sysref realign enable
	logic [1:0] phaseEn;         // Half-period shift per channel
	logic [2:0] dlyCtrl;         // Delay control code
	logic [1:0][7:0] fine;       // Fine value per channel
	logic [1:0][7:0] sfine;      // Superfine value per channel
	logic tick;                  // One per divided cycle
	modport top (output ratio, syncState, sysrefEn, phaseEn, dlyCtrl,
		fine, sfine, input tick);
	modport div (input ratio, syncState, sysrefEn, phaseEn,
		output tick);
	modport dly (input dlyCtrl, fine, sfine, tick);
endinterface
`default_nettype wire

// ==== rtl/scdd_delay.sv ====
// Fine and superfine delay decode and datapath flush.
// Assumes the tick marks each divided clock cycle.
`default_nettype none
module scdd_delay (
	input wire logic mclk,
	input wire logic rst,
	scdd_cfg_if.dly cfg,
	output logic [1:0][7:0] fineOut,
	output logic [1:0][7:0] sfineOut,
	output logic datapathRst,
	output logic sampleValid
);
	// ==========================================
	// State
	typedef struct packed {
		logic prevOn;             // Fine delay was enabled
		logic [4:0] flush;        // Divided cycles left in flush
		logic rstOut;             // Datapath reset level
		logic valid;              // Samples valid
		logic [1:0][7:0] fine;    // Effective fine steps
		logic [1:0][7:0] sf;      // Effective superfine steps
	} scdd_dly_t;
	scdd_dly_t q, d;
	logic on;
	// Next state: flush on enable, effective delays at once
	always_comb begin
		d = q;
		on = scdd_pkg::fineOn(cfg.dlyCtrl);
		d.prevOn = on;
		if (on && !q.prevOn) begin
			d.flush = scdd_pkg::FLUSH_TICKS;
		end else if (q.flush != 5'h00 && cfg.tick) begin
			d.flush = q.flush - 5'h01;
		end
		d.rstOut = d.flush != 5'h00;
		d.valid = !d.rstOut;
		for (int c = 0; c < scdd_pkg::NCH; c++) begin
			// 192-step or 16-step fine option
			if (!on) d.fine[c] = 8'h00;
			else if (cfg.dlyCtrl[scdd_pkg::DCTL_192_BIT])
				d.fine[c] = (cfg.fine[c] > scdd_pkg::FINE192_MAX) ?
					scdd_pkg::FINE192_MAX : cfg.fine[c];
			else d.fine[c] = cfg.fine[c] & scdd_pkg::FINE16_MAX;
			// Superfine gated by control code
			if (!scdd_pkg::sfineOn(cfg.dlyCtrl)) d.sf[c] = 8'h00;
			else d.sf[c] = (cfg.sfine[c] > scdd_pkg::SFINE_MAX) ?
				scdd_pkg::SFINE_MAX : cfg.sfine[c];
		end
	end
	// Register the state
	always_ff @(posedge mclk) begin
		if (rst) q <= '{valid: 1'b1, default: '0};
		else q <= d;
	end
	assign fineOut = q.fine;
	assign sfineOut = q.sf;
	assign datapathRst = q.rstOut;
	assign sampleValid = q.valid;
	// ==========================================
	// Checks
	property p_flush_start;
		@(posedge mclk) disable iff (rst)
		(scdd_pkg::fineOn(cfg.dlyCtrl) && !q.prevOn)
			|=> datapathRst && !sampleValid
				&& q.flush == scdd_pkg::FLUSH_TICKS;
	endproperty
	a_flush_start: assert property (p_flush_start)
		else $error("no flush on fine enable");
	property p_no_flush_value;
		@(posedge mclk) disable iff (rst)
		(q.prevOn && q.flush == 5'h00) |=> !datapathRst;
	endproperty
	a_no_flush_value: assert property (p_no_flush_value)
		else $error("flush without enable");
	property p_sf_gate;
		@(posedge mclk) disable iff (rst)
		(sfineOut != '0) |-> $past(scdd_pkg::sfineOn(cfg.dlyCtrl));
	endproperty
	a_sf_gate: assert property (p_sf_gate)
		else $error("superfine active on wrong code");
	property p_fine_range;
		@(posedge mclk) disable iff (rst)
		fineOut[0] <= scdd_pkg::FINE192_MAX
			&& fineOut[1] <= scdd_pkg::FINE192_MAX;
	endproperty
	a_fine_range: assert property (p_fine_range)
		else $error("fine delay out of range");
	c_flush_end: cover property (@(posedge mclk) disable iff (rst)
		$fell(datapathRst));
endmodule
`default_nettype wire

// ==== rtl/scdd_divider.sv ====
// Sample clock divider with sysref realign and half-period phase.
// Assumes sysref is synchronous to mclk.
`default_nettype none
module scdd_divider (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sysref,
	scdd_cfg_if.div cfg,
	output logic divClk,
	output logic [1:0] chanTick
);
	// ==========================================
	// State
	typedef struct packed {
		logic [1:0] cnt;      // Position in divided cycle
		logic sysPrev;        // Sysref of last cycle
		logic tick;           // Start of divided cycle
		logic divClk;         // Divided clock level
		logic [1:0] chTick;   // Per-channel shifted tick
	} scdd_div_t;
	scdd_div_t q, d;
	logic [1:0] last;
	logic [2:0] half;
	logic sysEdge;
	// Next state of the counter and outputs
	always_comb begin
		d = q;
		last = scdd_pkg::divLast(cfg.ratio);
		half = 3'((3'(last) + 3'h1) >> 1);
		sysEdge = cfg.sysrefEn && sysref && !q.sysPrev;
		d.sysPrev = sysref;
		if (sysEdge) begin
			d.cnt = cfg.syncState & last;
		end else if (q.cnt >= last) begin
			d.cnt = 2'h0;
		end else begin
			d.cnt = q.cnt + 2'h1;
		end
		d.tick = d.cnt == 2'h0;
		d.divClk = d.cnt <= (last >> 1);
		for (int c = 0; c < scdd_pkg::NCH; c++) begin
			d.chTick[c] = 3'(d.cnt) ==
				(cfg.phaseEn[c] ? half : 3'h0);
		end
	end
	// Register the state
	always_ff @(posedge mclk) begin
		if (rst) q <= '0;
		else q <= d;
	end
	assign cfg.tick = q.tick;
	assign divClk = q.divClk;
	assign chanTick = q.chTick;
	// ==========================================
	// Checks
	property p_sync_load;
		@(posedge mclk) disable iff (rst)
		(cfg.sysrefEn && sysref && !q.sysPrev)
			|=> q.cnt == (cfg.syncState & scdd_pkg::divLast(cfg.ratio));
	endproperty
	a_sync_load: assert property (p_sync_load)
		else $error("divider not loaded on sysref");
	property p_by4_period;
		@(posedge mclk) disable iff (rst)
		(q.tick && cfg.ratio == 2'h2 && !cfg.sysrefEn)
			|=> (!q.tick)[*3] ##1 q.tick;
	endproperty
	a_by4_period: assert property (p_by4_period)
		else $error("divide by four period wrong");
	property p_by2_duty;
		@(posedge mclk) disable iff (rst)
		(cfg.ratio == scdd_pkg::DIV_BY2 && !cfg.sysrefEn && q.divClk)
			|=> !q.divClk ##1 q.divClk;
	endproperty
	a_by2_duty: assert property (p_by2_duty)
		else $error("divide by two duty wrong");
	c_sync: cover property (@(posedge mclk) disable iff (rst)
		cfg.sysrefEn && sysref && !q.sysPrev);
endmodule
`default_nettype wire

// ==== rtl/scdd_pkg.sv ====
// Constants and decode helpers for the sample clock divider and delay.
// Assumes one register write port and one clock, mclk.
`default_nettype none
package scdd_pkg;
	// ==========================================
	// Register offsets
	localparam logic [15:0] ADDR_DIV = 16'h0108;
	localparam logic [15:0] ADDR_PHASE = 16'h0109;
	localparam logic [15:0] ADDR_DCTL = 16'h0110;
	localparam logic [15:0] ADDR_SFINE = 16'h0111;
	localparam logic [15:0] ADDR_FINE = 16'h0112;
	localparam logic [15:0] ADDR_DCSA = 16'h011c;
	localparam logic [15:0] ADDR_DCSB = 16'h011e;
	// ==========================================
	// Fields and reset values
	localparam int NCH = 2;
	localparam logic [1:0] DIV_BY1 = 2'h0;
	localparam logic [1:0] DIV_BY2 = 2'h1;
	localparam int SYNC_LSB = 4;
	localparam int SYSREF_EN_BIT = 7;
	localparam int DCTL_192_BIT = 2;
	localparam logic [2:0] DCTL_OFF = 3'h0;
	localparam logic [2:0] DCTL_SF_A = 3'h2;
	localparam logic [2:0] DCTL_SF_B = 3'h6;
	localparam logic [7:0] FINE16_MAX = 8'h0f;
	localparam logic [7:0] FINE192_MAX = 8'hbf;
	localparam logic [7:0] SFINE_MAX = 8'h7f;
	localparam int DCS_EN_BIT = 0;
	localparam logic [7:0] REG_ZERO = 8'h00;
	localparam logic [7:0] DCS_RESET = 8'h01;
	// Superfine step in femtoseconds
	localparam int SFINE_STEP_FS = 250;
	// Divided cycles the datapath is flushed for
	localparam logic [4:0] FLUSH_TICKS = 5'h10;
	// ==========================================
	// Decode helpers
	// Last count value of the divider for a ratio code
	function automatic logic [1:0] divLast(input logic [1:0] r);
		return (r == DIV_BY1) ? 2'h0 : (r == DIV_BY2) ? 2'h1 : 2'h3;
	endfunction
	// Fine delay active for any nonzero control code
	function automatic logic fineOn(input logic [2:0] c);
		return c != DCTL_OFF;
	endfunction
	// Superfine delay active only on two codes
	function automatic logic sfineOn(input logic [2:0] c);
		return (c == DCTL_SF_A) || (c == DCTL_SF_B);
	endfunction
endpackage
`default_nettype wire

// ==== rtl/scdd_top.sv ====
// Sample clock divider, phase and edge delay control with its registers.
// Assumes register writes and reads arrive as one-cycle strobes on mclk.
`default_nettype none
module scdd_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sysref,
	input wire logic [1:0] chanSelect,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [15:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic regRdValid,
	output logic divClk,
	output logic [1:0] chanTick,
	output logic [1:0][7:0] fineDelay,
	output logic [1:0][7:0] sfineDelay,
	output logic datapathRst,
	output logic sampleValid,
	output logic linkResync,
	output logic dcsStageOneEn,
	output logic dcsStageTwoEn
);
	// ==========================================
	// Register state
	typedef struct packed {
		logic [7:0] div;          // Divide ratio register
		logic [7:0] phase;        // Half-period phase register
		logic [7:0] dctl;         // Delay control register
		logic [1:0][7:0] sfine;   // Superfine per channel
		logic [1:0][7:0] fine;    // Fine per channel
		logic [7:0] dcsA;         // Stabilizer stage one control
		logic [7:0] dcsB;         // Stabilizer stage two control
		logic [7:0] rdData;       // Read answer
		logic rdValid;            // Read answer strobe
	} scdd_reg_t;
	scdd_reg_t q, d;
	// Channel whose copy is returned on reads
	logic rdCh;
	// Config carrier to the submodules
	scdd_cfg_if cfg ();

	// ==========================================
	// Register file next state
	always_comb begin
		d = q;
		d.rdValid = 1'b0;
		rdCh = !chanSelect[0];
		if (regWrEn) begin
			unique case (regAddr)
				// Ratio, sync state and sysref enable
				scdd_pkg::ADDR_DIV: d.div = regWrData;
				// Phase bits; no link action
				scdd_pkg::ADDR_PHASE: d.phase = regWrData;
				// Delay code, effective next cycle
				scdd_pkg::ADDR_DCTL: d.dctl = regWrData;
				// Superfine, selected channels only
				scdd_pkg::ADDR_SFINE: begin
					for (int c = 0; c < scdd_pkg::NCH; c++) begin
						if (chanSelect[c])
							d.sfine[c] = regWrData;
					end
				end
				// Fine, selected channels only
				scdd_pkg::ADDR_FINE: begin
					for (int c = 0; c < scdd_pkg::NCH; c++) begin
						if (chanSelect[c])
							d.fine[c] = regWrData;
					end
				end
				// Stabilizer stages
				scdd_pkg::ADDR_DCSA: d.dcsA = regWrData;
				scdd_pkg::ADDR_DCSB: d.dcsB = regWrData;
				// Unmapped writes are dropped
				default: ;
			endcase
		end
		if (regRdEn) begin
			d.rdValid = 1'b1;
			unique case (regAddr)
				scdd_pkg::ADDR_DIV: d.rdData = q.div;
				scdd_pkg::ADDR_PHASE: d.rdData = q.phase;
				scdd_pkg::ADDR_DCTL: d.rdData = q.dctl;
				scdd_pkg::ADDR_SFINE: d.rdData = q.sfine[rdCh];
				scdd_pkg::ADDR_FINE: d.rdData = q.fine[rdCh];
				scdd_pkg::ADDR_DCSA: d.rdData = q.dcsA;
				scdd_pkg::ADDR_DCSB: d.rdData = q.dcsB;
				// Unmapped reads answer zero
				default: d.rdData = scdd_pkg::REG_ZERO;
			endcase
		end
	end

	// ==========================================
	// Register file flops
	always_ff @(posedge mclk) begin
		if (rst) begin
			q <= '0;
			q.dcsA <= scdd_pkg::DCS_RESET;
			q.dcsB <= scdd_pkg::DCS_RESET;
		end else begin
			q <= d;
		end
	end

	// ==========================================
	// Config to submodules
	assign cfg.ratio = q.div[1:0];
	assign cfg.syncState = q.div[scdd_pkg::SYNC_LSB +: 2];
	assign cfg.sysrefEn = q.div[scdd_pkg::SYSREF_EN_BIT];
	assign cfg.phaseEn = q.phase[1:0];
	assign cfg.dlyCtrl = q.dctl[2:0];
	assign cfg.fine = q.fine;
	assign cfg.sfine = q.sfine;

	// Divider with sysref realign and phase
	scdd_divider uDiv (
		.mclk(mclk),
		.rst(rst),
		.sysref(sysref),
		.cfg(cfg.div),
		.divClk(divClk),
		.chanTick(chanTick)
	);

	// Delay decode and datapath flush
	scdd_delay uDly (
		.mclk(mclk),
		.rst(rst),
		.cfg(cfg.dly),
		.fineOut(fineDelay),
		.sfineOut(sfineDelay),
		.datapathRst(datapathRst),
		.sampleValid(sampleValid)
	);

	// ==========================================
	// Outputs straight from flops
	assign regRdData = q.rdData;
	assign regRdValid = q.rdValid;
	assign dcsStageOneEn = q.dcsA[scdd_pkg::DCS_EN_BIT];
	assign dcsStageTwoEn = q.dcsB[scdd_pkg::DCS_EN_BIT];
	// Link is never resynced by phase or value writes
	assign linkResync = q.rdValid & 1'b0;

	// ==========================================
	// Checks
	property p_dcs_reset;
		@(posedge mclk)
		$fell(rst) |-> dcsStageOneEn && dcsStageTwoEn;
	endproperty
	a_dcs_reset: assert property (p_dcs_reset)
		else $error("stabilizer not enabled after reset");
	property p_dctl_now;
		@(posedge mclk) disable iff (rst)
		(regWrEn && regAddr == scdd_pkg::ADDR_DCTL
			&& regWrData[2:0] == scdd_pkg::DCTL_OFF)
			|=> ##1 fineDelay == '0 && sfineDelay == '0;
	endproperty
	a_dctl_now: assert property (p_dctl_now)
		else $error("delay disable not immediate");
	property p_fine_sel;
		@(posedge mclk) disable iff (rst)
		(regWrEn && regAddr == scdd_pkg::ADDR_FINE && chanSelect == 2'h1)
			|=> q.fine[0] == $past(regWrData)
				&& $stable(q.fine[1]);
	endproperty
	a_fine_sel: assert property (p_fine_sel)
		else $error("fine write hit wrong channel");
	property p_phase_no_reset;
		@(posedge mclk) disable iff (rst)
		(regWrEn && regAddr == scdd_pkg::ADDR_PHASE && !datapathRst)
			|=> ##1 !datapathRst;
	endproperty
	a_phase_no_reset: assert property (p_phase_no_reset)
		else $error("phase write disturbed datapath");
	property p_sf_value;
		@(posedge mclk) disable iff (rst)
		(scdd_pkg::sfineOn(q.dctl[2:0]) && q.sfine[0] <= scdd_pkg::SFINE_MAX
			&& $stable(q.sfine[0]) && $stable(q.dctl))
			|=> sfineDelay[0] == $past(q.sfine[0]);
	endproperty
	a_sf_value: assert property (p_sf_value)
		else $error("superfine value not applied");
	property p_rd_answer;
		@(posedge mclk) disable iff (rst)
		(regRdEn && regAddr == scdd_pkg::ADDR_DIV)
			|=> regRdValid && regRdData == $past(q.div);
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer wrong");

	// ==========================================
	// Checks on register effects and the divider outputs
	// Value writes with the code steady never flush
	property p_val_steady;
		@(posedge mclk) disable iff (rst)
		(regWrEn && (regAddr == scdd_pkg::ADDR_FINE
			|| regAddr == scdd_pkg::ADDR_SFINE)
			&& $stable(q.dctl) && !datapathRst)
			|=> !datapathRst;
	endproperty
	a_val_steady: assert property (p_val_steady)
		else $error("value write flushed datapath");

	// Fine write to channel B only
	property p_fine_sel_b;
		@(posedge mclk) disable iff (rst)
		(regWrEn && regAddr == scdd_pkg::ADDR_FINE && chanSelect == 2'h2)
			|=> q.fine[1] == $past(regWrData)
				&& $stable(q.fine[0]);
	endproperty
	a_fine_sel_b: assert property (p_fine_sel_b)
		else $error("fine write hit channel A");

	// Superfine write to channel A only
	property p_sfine_sel_a;
		@(posedge mclk) disable iff (rst)
		(regWrEn && regAddr == scdd_pkg::ADDR_SFINE && chanSelect == 2'h1)
			|=> q.sfine[0] == $past(regWrData)
				&& $stable(q.sfine[1]);
	endproperty
	a_sfine_sel_a: assert property (p_sfine_sel_a)
		else $error("superfine write hit channel B");

	// Stage one enable follows its control bit
	property p_dcs_one_wr;
		@(posedge mclk) disable iff (rst)
		(regWrEn && regAddr == scdd_pkg::ADDR_DCSA)
			|=> dcsStageOneEn == $past(regWrData[scdd_pkg::DCS_EN_BIT]);
	endproperty
	a_dcs_one_wr: assert property (p_dcs_one_wr)
		else $error("stage one enable not written");

	// Stage two enable follows its control bit
	property p_dcs_two_wr;
		@(posedge mclk) disable iff (rst)
		(regWrEn && regAddr == scdd_pkg::ADDR_DCSB)
			|=> dcsStageTwoEn == $past(regWrData[scdd_pkg::DCS_EN_BIT]);
	endproperty
	a_dcs_two_wr: assert property (p_dcs_two_wr)
		else $error("stage two enable not written");

	// Read answer strobe stands only after a read
	property p_rd_pulse;
		@(posedge mclk) disable iff (rst)
		!regRdEn |=> !regRdValid;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse)
		else $error("read valid without read");

	// Fine read returns channel A when its select bit is set
	property p_rd_chan;
		@(posedge mclk) disable iff (rst)
		(regRdEn && regAddr == scdd_pkg::ADDR_FINE && chanSelect[0])
			|=> regRdData == $past(q.fine[0]);
	endproperty
	a_rd_chan: assert property (p_rd_chan)
		else $error("fine read from wrong channel");

	// Ratio field reaches the divider at once
	property p_ratio_load;
		@(posedge mclk) disable iff (rst)
		(regWrEn && regAddr == scdd_pkg::ADDR_DIV)
			|=> cfg.ratio == $past(regWrData[1:0]);
	endproperty
	a_ratio_load: assert property (p_ratio_load)
		else $error("divide ratio not loaded");

	// Divide by one: clock high, both channels tick every cycle
	property p_by1_steady;
		@(posedge mclk) disable iff (rst)
		(cfg.ratio == scdd_pkg::DIV_BY1) |=> divClk && (&chanTick);
	endproperty
	a_by1_steady: assert property (p_by1_steady)
		else $error("divide by one output wrong");

	// Flush seen starting
	c_flush: cover property (@(posedge mclk) disable iff (rst)
		$rose(datapathRst));
	c_sf_mode: cover property (@(posedge mclk) disable iff (rst)
		sfineDelay[1] != '0);
	c_by4: cover property (@(posedge mclk) disable iff (rst)
		cfg.ratio == 2'h2 && divClk);
endmodule
`default_nettype wire

// ==== tb/sample_clock_divider_delay_tb_top.sv ====
// Self-checking bench for the divider, phase and delay control.
// Assumes the design's package and a sysref model in scdd_ref_gen.
`default_nettype none
module sample_clock_divider_delay_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Stimulus and observed signals
	logic mclk = 1'b0, rst = 1'b1, fire = 1'b0, sysref;
	logic [1:0] chanSelect = 2'h3; // Both channels written
	logic regWrEn = 1'b0, regRdEn = 1'b0;
	logic [15:0] regAddr = 16'h0000;
	logic [7:0] regWrData = 8'h00, regRdData, v;
	logic regRdValid, divClk, datapathRst, sampleValid, linkResync;
	logic dcsStageOneEn, dcsStageTwoEn;
	logic [1:0] chanTick;
	logic [1:0][7:0] fineDelay, sfineDelay;
	int badCount = 0, compares = 0, n, hi, tk, d0, d2, dx;
	// Delay table row: control, fine, superfine, expected effect
	typedef struct packed {
		logic [2:0] c;
		logic [7:0] f, s, ef, es;
	} scdd_dly_t;
	scdd_dly_t dRows[9] = '{'{3'h0, 8'h55, 8'h22, 8'h00, 8'h00},
		'{3'h1, 8'h35, 8'h22, 8'h05, 8'h00},
		'{3'h2, 8'h35, 8'h22, 8'h05, 8'h22},
		'{3'h3, 8'h1f, 8'h22, 8'h0f, 8'h00},
		'{3'h4, 8'hc5, 8'h22, 8'hbf, 8'h00},
		'{3'h5, 8'h40, 8'h80, 8'h40, 8'h00},
		'{3'h6, 8'hbf, 8'hff, 8'hbf, 8'h7f},
		'{3'h7, 8'h10, 8'h10, 8'h10, 8'h00},
		'{3'h2, 8'hff, 8'h80, 8'h0f, 8'h7f}};
	logic [15:0] rAddr[7] = '{scdd_pkg::ADDR_DIV, scdd_pkg::ADDR_PHASE,
		scdd_pkg::ADDR_DCTL, scdd_pkg::ADDR_SFINE, scdd_pkg::ADDR_FINE,
		scdd_pkg::ADDR_DCSA, scdd_pkg::ADDR_DCSB};
	logic [7:0] rVal[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
	logic [7:0] divTk[4] = '{8'h08, 8'h04, 8'h02, 8'h02}; // Ticks in 8
	logic [7:0] divHi[4] = '{8'h08, 8'h04, 8'h04, 8'h04}; // High in 8
	// ==========================================
	// Design and sysref source
	scdd_top dut (.mclk(mclk), .rst(rst), .sysref(sysref),
		.chanSelect(chanSelect), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .divClk(divClk), .chanTick(chanTick),
		.fineDelay(fineDelay), .sfineDelay(sfineDelay),
		.datapathRst(datapathRst), .sampleValid(sampleValid),
		.linkResync(linkResync), .dcsStageOneEn(dcsStageOneEn),
		.dcsStageTwoEn(dcsStageTwoEn));
	scdd_ref_gen #(.HOLD(2)) gen (.mclk(mclk), .fire(fire),
		.sysref(sysref));
	// Clock at 50 MHz
	always #10 mclk = ~mclk;
	// ==========================================
	// Shared tasks
	// Compare and report one value
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			badCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic tallyAndFinish();
		$display("Checks %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// One-cycle write strobe; returns at the edge that takes it
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWrEn <= 1'b0;
	endtask
	// One-cycle read strobe; answer stands one cycle later
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRdEn <= 1'b0;
		#1;
		check("rdValid", 8'(regRdValid), 8'h01);
		d = regRdData;
	endtask
	// Let a write reach the delay outputs
	task automatic settle();
		repeat (2) @(posedge mclk);
		#1;
	endtask
	// Reset held for five cycles, then reset values checked
	task automatic doReset();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(rAddr[i], v);
			check("resetVal", v, rVal[i]);
		end
		check("dcsOne", 8'(dcsStageOneEn), 8'h01);
		check("dcsTwo", 8'(dcsStageTwoEn), 8'h01);
		check("validAtReset", 8'(sampleValid), 8'h01);
	endtask
	// Wait bounded for a channel A tick
	task automatic waitTick();
		n = 0;
		while (chanTick[0] !== 1'b1 && n < 10) begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask
	// Fire sysref, then find the tick phase relative to it
	task automatic srDelay(output int d);
		@(posedge mclk);
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		waitTick();
		d = n;
	endtask
	// ==========================================
	// Watchdog: far beyond the expected run length
	initial begin
		repeat (20000) @(posedge mclk);
		badCount++;
		$display("Watchdog expired");
		tallyAndFinish();
	end
	// ==========================================
	// Main sequence
	initial begin
		doReset();
		wr(scdd_pkg::ADDR_DIV, 8'h00);
		// Delay decode rows, same settings on both channels
		foreach (dRows[i]) begin
			wr(scdd_pkg::ADDR_DCTL, {5'h00, dRows[i].c});
			wr(scdd_pkg::ADDR_FINE, dRows[i].f);
			wr(scdd_pkg::ADDR_SFINE, dRows[i].s);
			settle();
			check("fine", fineDelay[0], dRows[i].ef);
			check("sfine", sfineDelay[1], dRows[i].es);
			rd(scdd_pkg::ADDR_DCTL, v);
			check("dctlRead", v, {5'h00, dRows[i].c});
			rd(scdd_pkg::ADDR_FINE, v);
			check("fineRead", v, dRows[i].f);
		end
		// Separate values per channel
		@(posedge mclk);
		chanSelect <= 2'h1;
		wr(scdd_pkg::ADDR_FINE, 8'h21);
		wr(scdd_pkg::ADDR_SFINE, 8'h31);
		@(posedge mclk);
		chanSelect <= 2'h2;
		wr(scdd_pkg::ADDR_FINE, 8'h42);
		wr(scdd_pkg::ADDR_SFINE, 8'h52);
		settle();
		check("fineA", fineDelay[0], 8'h01);
		check("fineB", fineDelay[1], 8'h02);
		check("sfineA", sfineDelay[0], 8'h31);
		check("sfineB", sfineDelay[1], 8'h52);
		chanSelect <= 2'h3;
		// Flush on enabling fine delay, divide by one
		wr(scdd_pkg::ADDR_DCTL, 8'h00);
		repeat (40) @(posedge mclk);
		wr(scdd_pkg::ADDR_DCTL, 8'h01);
		#1;
		check("rstEarly", 8'(datapathRst), 8'h00);
		@(posedge mclk);
		#1;
		check("rstOn", 8'(datapathRst), 8'h01);
		check("validOff", 8'(sampleValid), 8'h00);
		n = 1;
		while (datapathRst === 1'b1 && n < 40) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check("flushLen", 8'(n >= 16 && n <= 17), 8'h01);
		check("validBack", 8'(sampleValid), 8'h01);
		// Code and value changes while enabled do not flush
		wr(scdd_pkg::ADDR_DCTL, 8'h04);
		wr(scdd_pkg::ADDR_FINE, 8'h33);
		settle();
		check("noFlush", 8'(datapathRst), 8'h00);
		check("linkHold", 8'(linkResync), 8'h00);
		// Ratio codes: ticks and high cycles over eight clocks
		for (int r = 0; r < 4; r++) begin
			wr(scdd_pkg::ADDR_DIV, 8'(r));
			repeat (8) @(posedge mclk);
			hi = 0;
			tk = 0;
			for (int k = 0; k < 8; k++) begin
				@(posedge mclk);
				#1;
				hi += int'(divClk === 1'b1);
				tk += int'(chanTick[0] === 1'b1);
			end
			check("ticks", 8'(tk), divTk[r]);
			check("duty", 8'(hi), divHi[r]);
		end
		// Half-period shift on channel B at divide by four
		wr(scdd_pkg::ADDR_PHASE, 8'h02);
		settle();
		waitTick();
		n = 0;
		while (chanTick[1] !== 1'b1 && n < 8) begin
			@(posedge mclk);
			#1;
			n++;
		end
		check("phaseB", 8'(n), 8'h02);
		check("linkPhase", 8'(linkResync), 8'h00);
		wr(scdd_pkg::ADDR_PHASE, 8'h00);
		settle();
		waitTick();
		check("phaseOff", 8'(chanTick[1]), 8'h01);
		// Sysref realign to state 0, then 2, then repeat at offsets of one and two cycles
		wr(scdd_pkg::ADDR_DIV, 8'h82);
		srDelay(d0);
		wr(scdd_pkg::ADDR_DIV, 8'ha2);
		srDelay(d2);
		check("syncStep", 8'((d2 - d0) & 3), 8'h02);
		for (int w = 1; w < 3; w++) begin
			repeat (w) @(posedge mclk);
			srDelay(dx);
			check("syncSame", 8'(dx), 8'(d2));
		end
		// Duty stabilizer off and unmapped access
		wr(scdd_pkg::ADDR_DCSA, 8'h00);
		wr(scdd_pkg::ADDR_DCSB, 8'h00);
		wr(16'h0100, 8'h5a);
		settle();
		check("dcsOneOff", 8'(dcsStageOneEn), 8'h00);
		check("dcsTwoOff", 8'(dcsStageTwoEn), 8'h00);
		rd(16'h0100, v);
		check("unmapped", v, 8'h00);
		rd(scdd_pkg::ADDR_DIV, v);
		check("divRead", v, 8'ha2);
		// Second reset at the end of the run
		doReset();
		tallyAndFinish();
	end
endmodule
`default_nettype wire

// ==== tb/scdd_ref_gen.sv ====
// Behavioural sysref source standing in front of the clock divider.
// Assumes fire is driven on the rising edge of mclk by the bench.
`default_nettype none
module scdd_ref_gen #(
	parameter int HOLD = 2
) (
	input wire logic mclk,
	input wire logic fire,
	output logic sysref
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Pulse generation
	int left = 0; // High cycles still owed
	// A request opens a pulse of HOLD cycles; the line idles low between
	always @(posedge mclk) begin
		if (fire) begin
			left <= HOLD;
		end else if (left != 0) begin
			left <= left - 1;
		end
	end
	// Rising edge of this level is the realign event
	assign sysref = (left != 0);
endmodule
`default_nettype wire
